// *** verilog/irq_pm_pkg.sv ***
// constants shared by the interrupt dispatch and power-mode block
// assumes one 100 MHz clock and a plain strobe register port
package irq_pm_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int REG_AW = 4;
  // register offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h1;
  localparam logic [3:0] OFS_TRIG = 4'h2;
  localparam logic [3:0] OFS_TABLE = 4'h3;
  localparam logic [3:0] OFS_POWER = 4'h4;
  localparam logic [3:0] OFS_VECTOR = 4'h5;
  localparam logic [3:0] OFS_TRAP = 4'h6;
  // power register field positions
  localparam int PWR_DEEP_BIT = 0;
  localparam int PWR_SLOW_BIT = 1;
  // vector table layout
  localparam int TABLE_ALIGN_W = 8;
  localparam int SLOT_W = 6;
  localparam logic [ADDR_W-1:0] RESET_VECTOR = 24'h000000;
  localparam logic [5:0] SLOT_EXT0 = 6'h01;
  localparam logic [5:0] SLOT_SER_TX = 6'h05;
  localparam logic [5:0] SLOT_SER_RX = 6'h06;
  localparam logic [5:0] SLOT_TIM0 = 6'h09;
  localparam logic [5:0] SLOT_TIM1 = 6'h0A;
  localparam logic [5:0] SLOT_DMA0 = 6'h0B;
  localparam logic [5:0] SLOT_DMA1 = 6'h0C;
  localparam logic [5:0] SLOT_SOFT_FIRST = 6'h20;
  // reset values
  localparam logic [15:0] TABLE_RST = 16'h0000;
  localparam logic [3:0] TRIG_RST = 4'h0;
  localparam logic [9:0] MASK_RST = 10'h000;
  // slow-clock divide ratio
  localparam int SLOW_DIV = 16;
  localparam int N_SRC = 10;
  typedef enum logic [1:0] {PM_RUN, PM_DEEP, PM_WAKE} pm_state_t;
endpackage : irq_pm_pkg

// *** verilog/ext_irq_detect.sv ***
// one external interrupt detector, edge or level selectable
// assumes the pin is already synchronous to mclk_i
`timescale 1ns/1ps
module ext_irq_detect (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  input wire logic edge_mode_i,
  output logic event_o
);
  logic pin_ff;
  logic nxt_pin;
  // ==========================================
  // edge or level decision
  always_comb begin
    nxt_pin = pin_i;
    event_o = edge_mode_i ? (pin_i & ~pin_ff) : pin_i;
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end
endmodule : ext_irq_detect

// *** verilog/clk_div_en.sv ***
// divider giving a one-cycle enable every DIV clocks
// assumes a single clock; no gated clocks are made
`timescale 1ns/1ps
module clk_div_en #(
  parameter int DIV = 16
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic en_o
);
  localparam int CNT_W = $clog2(DIV);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DIV - 1);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  // ==========================================
  // counter wraps and pulses on terminal count
  always_comb begin
    nxt_cnt = run_i ? cnt_ff + 1'b1 : '0;
    if (run_i && cnt_ff == CNT_LAST) begin
      nxt_cnt = '0;
    end
    en_o = run_i && (cnt_ff == CNT_LAST);
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : clk_div_en

// *** verilog/irq_vector_and_power_modes.sv ***
// interrupt dispatch, vector addressing and power modes
// assumes core acknowledges vectors with vec_ack_i, one clock mclk_i
`timescale 1ns/1ps
// Functional notes
// - external interrupts each selectable edge or level detection
// - table pointer relocatable, base forced to 256-word alignment
// - reset vector always address zero
// - external irqs zero to three at slots 01h to 04h
// - serial transmit at 05h, receive at 06h
// - timer zero at 09h, timer one at 0Ah
// - dma zero at 0Bh, dma one at 0Ch
// - slots 00h, 07h, 08h, 0Dh-1Fh never assigned
// - software traps zero to thirty-one at 20h to 3Fh
// - deep idle stops execution, keeps state, bus outputs idle
// - deep idle holds phase one high, phase three low until wake
// - slow clock mode runs cpu and dma at input clock over 16
module irq_vector_and_power_modes
  import irq_pm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [irq_pm_pkg::REG_AW-1:0] addr_i,
  input wire logic [irq_pm_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [irq_pm_pkg::DATA_W-1:0] rdata_o,
  input wire logic [3:0] ext_irq_i,
  input wire logic serial_tx_irq_i,
  input wire logic serial_rx_irq_i,
  input wire logic timer_zero_irq_i,
  input wire logic timer_one_irq_i,
  input wire logic dma_zero_irq_i,
  input wire logic dma_one_irq_i,
  input wire logic vec_ack_i,
  output logic vec_req_o,
  output logic [irq_pm_pkg::ADDR_W-1:0] vec_addr_o,
  output logic cpu_en_o,
  output logic bus_idle_o,
  output logic out_clock_phase_one_o,
  output logic out_clock_phase_three_o,
  output logic irq_o
);
  import irq_pm_pkg::*;

  // ==========================================
  // external detectors
  logic [3:0] ext_evt;
  logic [3:0] trig_ff;
  logic [3:0] nxt_trig;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ext
      ext_irq_detect ext_irq_detect_inst (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .pin_i(ext_irq_i[gi]),
        .edge_mode_i(trig_ff[gi]),
        .event_o(ext_evt[gi])
      );
    end
  endgenerate

  // ==========================================
  // state
  logic [N_SRC-1:0] status_ff, nxt_status;
  logic [N_SRC-1:0] mask_ff, nxt_mask;
  logic [15:0] table_ff, nxt_table;
  logic slow_ff, nxt_slow;
  logic nxt_deep_req;
  pm_state_t pm_ff, nxt_pm;
  logic vec_req_ff, nxt_vec_req;
  logic [ADDR_W-1:0] vec_addr_ff, nxt_vec_addr;
  logic [4:0] trap_num_ff, nxt_trap_num;
  logic trap_pend_ff, nxt_trap_pend;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic ph_ff, nxt_ph;
  logic ph3_ff, nxt_ph3;
  logic cpu_en_ff, nxt_cpu_en;
  logic idle_ff, nxt_idle;
  logic irq_ff, nxt_irq;
  logic slow_en;
  logic [N_SRC-1:0] src;
  logic [N_SRC-1:0] pend;
  logic [5:0] slot;
  logic slot_hit;
  logic wake;

  // slow rate enable; full rate when not in slow mode
  clk_div_en #(
    .DIV(SLOW_DIV)
  ) clk_div_en_inst (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .run_i(slow_ff),
    .en_o(slow_en)
  );

  // source order: ext0..3, ser tx, ser rx, tim0, tim1, dma0, dma1
  assign src = {dma_one_irq_i, dma_zero_irq_i, timer_one_irq_i,
                timer_zero_irq_i, serial_rx_irq_i, serial_tx_irq_i,
                ext_evt};
  assign pend = status_ff & mask_ff;
  assign wake = |ext_evt;

  // ==========================================
  // slot selection, a pending trap wins, else lowest slot wins
  always_comb begin
    slot = 6'h00;
    slot_hit = 1'b0;
    if (trap_pend_ff) begin
      slot = SLOT_SOFT_FIRST + {1'b0, trap_num_ff};
      slot_hit = 1'b1;
    end else if (|pend[3:0]) begin
      slot_hit = 1'b1;
      for (int i = 3; i >= 0; i--) begin
        if (pend[i]) begin
          slot = SLOT_EXT0 + 6'(i);
        end
      end
    end else if (pend[4]) begin
      slot = SLOT_SER_TX;
      slot_hit = 1'b1;
    end else if (pend[5]) begin
      slot = SLOT_SER_RX;
      slot_hit = 1'b1;
    end else if (pend[6]) begin
      slot = SLOT_TIM0;
      slot_hit = 1'b1;
    end else if (pend[7]) begin
      slot = SLOT_TIM1;
      slot_hit = 1'b1;
    end else if (pend[8]) begin
      slot = SLOT_DMA0;
      slot_hit = 1'b1;
    end else if (pend[9]) begin
      slot = SLOT_DMA1;
      slot_hit = 1'b1;
    end
    // slots 00h, 07h, 08h, 0Dh-1Fh have no source mapped
  end

  // ==========================================
  // registers, dispatch and power modes
  always_comb begin
    nxt_status = status_ff;
    nxt_mask = mask_ff;
    nxt_trig = trig_ff;
    nxt_table = table_ff;
    nxt_slow = slow_ff;
    nxt_deep_req = 1'b0;
    nxt_pm = pm_ff;
    nxt_vec_req = vec_req_ff;
    nxt_vec_addr = vec_addr_ff;
    nxt_trap_num = trap_num_ff;
    nxt_trap_pend = trap_pend_ff;
    nxt_rdata = '0;
    nxt_ph = ph_ff;
    nxt_cpu_en = 1'b0;
    nxt_idle = 1'b0;
    // write-one-to-clear; set below wins
    if (wr_i) begin
      unique case (addr_i)
        OFS_STATUS: nxt_status = status_ff & ~wdata_i[N_SRC-1:0];
        OFS_MASK: nxt_mask = wdata_i[N_SRC-1:0];
        OFS_TRIG: nxt_trig = wdata_i[3:0];
        OFS_TABLE: nxt_table = wdata_i[15:0];
        OFS_POWER: begin
          nxt_slow = wdata_i[PWR_SLOW_BIT];
          nxt_deep_req = wdata_i[PWR_DEEP_BIT];
        end
        OFS_TRAP: begin
          nxt_trap_num = wdata_i[4:0];
          nxt_trap_pend = 1'b1;
        end
        default: ;
      endcase
    end
    nxt_status = nxt_status | src;
    if (rd_i) begin
      unique case (addr_i)
        OFS_STATUS: nxt_rdata = DATA_W'(status_ff);
        OFS_MASK: nxt_rdata = DATA_W'(mask_ff);
        OFS_TRIG: nxt_rdata = DATA_W'(trig_ff);
        OFS_TABLE: nxt_rdata = DATA_W'(table_ff);
        OFS_POWER: nxt_rdata = DATA_W'({slow_ff, pm_ff == PM_DEEP});
        OFS_VECTOR: nxt_rdata = DATA_W'(vec_addr_ff);
        default: nxt_rdata = '0;
      endcase
    end
    unique case (pm_ff)
      PM_RUN: begin
        nxt_cpu_en = slow_ff ? slow_en : 1'b1;
        if (slow_ff) begin
          nxt_ph = slow_en ? ~ph_ff : ph_ff;
        end else begin
          nxt_ph = ~ph_ff;
        end
        if (nxt_deep_req) begin
          nxt_pm = PM_DEEP;
        end
        if (vec_ack_i && vec_req_ff) begin
          nxt_vec_req = 1'b0;
          // retire the slot that was offered, not whatever wins now;
          // a trap written or an event seen in the ack cycle survives
          if (vec_addr_ff[5:0] >= SLOT_SOFT_FIRST) begin
            nxt_trap_pend = wr_i && (addr_i == OFS_TRAP);
          end else begin
            nxt_status = (nxt_status &
              ~(N_SRC'(1) << slot_idx(vec_addr_ff[5:0]))) | src;
          end
        end else if (!vec_req_ff && slot_hit) begin
          nxt_vec_req = 1'b1;
          // aligned base plus slot
          nxt_vec_addr = {table_ff, 2'b00, slot};
        end
      end
      PM_DEEP: begin
        nxt_ph = 1'b1;
        nxt_idle = 1'b1;
        if (wake) begin
          nxt_pm = PM_WAKE;
        end
      end
      PM_WAKE: begin
        // clocks run one cycle before dispatch resumes
        nxt_ph = ~ph_ff;
        nxt_pm = PM_RUN;
      end
      default: nxt_pm = PM_RUN;
    endcase
    nxt_irq = |(nxt_status & nxt_mask);
    nxt_ph3 = ~nxt_ph;
  end

  // slot back to status bit index
  function automatic int slot_idx(input logic [5:0] s);
    int r;
    r = 0;
    unique case (s)
      SLOT_SER_TX: r = 4;
      SLOT_SER_RX: r = 5;
      SLOT_TIM0: r = 6;
      SLOT_TIM1: r = 7;
      SLOT_DMA0: r = 8;
      SLOT_DMA1: r = 9;
      default: r = int'(s) - int'(SLOT_EXT0);
    endcase
    return r;
  endfunction : slot_idx

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_ff <= '0;
      mask_ff <= MASK_RST;
      trig_ff <= TRIG_RST;
      table_ff <= TABLE_RST;
      slow_ff <= 1'b0;
      pm_ff <= PM_RUN;
      vec_req_ff <= 1'b0;
      vec_addr_ff <= RESET_VECTOR;
      trap_num_ff <= '0;
      trap_pend_ff <= 1'b0;
      rdata_ff <= '0;
      ph_ff <= 1'b1;
      ph3_ff <= 1'b0;
      cpu_en_ff <= 1'b0;
      idle_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      trig_ff <= nxt_trig;
      table_ff <= nxt_table;
      slow_ff <= nxt_slow;
      pm_ff <= nxt_pm;
      vec_req_ff <= nxt_vec_req;
      vec_addr_ff <= nxt_vec_addr;
      trap_num_ff <= nxt_trap_num;
      trap_pend_ff <= nxt_trap_pend;
      rdata_ff <= nxt_rdata;
      ph_ff <= nxt_ph;
      ph3_ff <= nxt_ph3;
      cpu_en_ff <= nxt_cpu_en;
      idle_ff <= nxt_idle;
      irq_ff <= nxt_irq;
    end
  end

  // phase three has its own flop so every output leaves a register;
  // it always holds the complement, both frozen in deep idle
  assign rdata_o = rdata_ff;
  assign vec_req_o = vec_req_ff;
  assign vec_addr_o = vec_addr_ff;
  assign cpu_en_o = cpu_en_ff;
  assign bus_idle_o = idle_ff;
  assign out_clock_phase_one_o = ph_ff;
  assign out_clock_phase_three_o = ph3_ff;
  assign irq_o = irq_ff;
endmodule : irq_vector_and_power_modes

// *** dv/core_ack_model.sv ***
// model of the core side that accepts vector requests
// assumes the bench sets the accept delay, one clock mclk_i
`timescale 1ns/1ps
module core_ack_model (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic vec_req_i,
  input wire logic [3:0] delay_i,
  output logic vec_ack_o
);
  logic [3:0] wait_ff;
  // ==========================
  // accept after delay_i cycles, ack is a one-cycle pulse
  // a slow core keeps the request standing, a prompt one does not
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_ff <= 4'h0;
      vec_ack_o <= 1'b0;
    end else begin
      vec_ack_o <= vec_req_i && !vec_ack_o && wait_ff >= delay_i;
      wait_ff <= (vec_req_i && !vec_ack_o) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule : core_ack_model

// *** dv/irq_pm_chk.sv ***
// checker on the vector and power-mode ports
// assumes it is bound to the top module, one clock domain
`timescale 1ns/1ps
module irq_pm_chk
  import irq_pm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [3:0] ext_irq_i,
  input wire logic vec_ack_i,
  input wire logic vec_req_o,
  input wire logic [irq_pm_pkg::ADDR_W-1:0] vec_addr_o,
  input wire logic cpu_en_o,
  input wire logic bus_idle_o,
  input wire logic out_clock_phase_one_o,
  input wire logic out_clock_phase_three_o
);
  logic [3:0] quiet_ff;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================
  // cycles with all pins low; the wake path lags a few cycles
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) quiet_ff <= 4'h0;
    else if (ext_irq_i != 4'h0) quiet_ff <= 4'h0;
    else if (quiet_ff != 4'hF) quiet_ff <= quiet_ff + 4'h1;
  end
  // ==========================
  // vector and power-mode properties
  a_vec_align: assert property (
    vec_req_o |-> vec_addr_o[7:6] == 2'b00) else $error("vector unaligned");
  a_slot_legal: assert property (
    vec_req_o |-> vec_addr_o[5:0] inside {[6'h01:6'h06], [6'h09:6'h0C],
    [6'h20:6'h3F]}) else $error("reserved slot used");
  a_req_holds: assert property (
    vec_req_o && !vec_ack_i |=> vec_req_o && $stable(vec_addr_o))
    else $error("vector request dropped");
  a_ack_drops: assert property (
    vec_req_o && vec_ack_i |=> !vec_req_o) else $error("request kept");
  a_idle_phase: assert property (
    bus_idle_o && quiet_ff > 4'h5 |-> out_clock_phase_one_o &&
    !out_clock_phase_three_o) else $error("phases move in deep idle");
  a_idle_noexec: assert property (
    bus_idle_o && quiet_ff > 4'h5 |-> !cpu_en_o) else $error("runs idle");
  a_phase_pair: assert property (
    out_clock_phase_three_o == !out_clock_phase_one_o)
    else $error("phases not paired");
  a_wake_irq: assert property (
    bus_idle_o && |(ext_irq_i & ~$past(ext_irq_i)) |-> ##[1:4] !bus_idle_o)
    else $error("no wake on pin");
  a_stay_idle: assert property (
    bus_idle_o && quiet_ff > 4'h5 |=> bus_idle_o) else $error("woke alone");
endmodule : irq_pm_chk
bind irq_vector_and_power_modes irq_pm_chk irq_pm_chk_inst (.mclk_i,
  .nrst_i, .ext_irq_i, .vec_ack_i, .vec_req_o, .vec_addr_o, .cpu_en_o,
  .bus_idle_o, .out_clock_phase_one_o, .out_clock_phase_three_o);

// *** dv/irq_vector_and_power_modes_bench.sv ***
// bench for vectors, traps, trigger modes and power modes
// assumes the core model and checker, one 100 MHz clock
`timescale 1ns/1ps
module irq_vector_and_power_modes_bench;
  import irq_pm_pkg::*;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_d = 1'b0;
  logic [9:0] src = 10'h000;
  logic [3:0] delay = 4'h0;
  logic [15:0] ptr = 16'h0000;
  logic [31:0] seed = 32'h360D031E;
  logic [31:0] r, n, rdata_o;
  logic [23:0] vec_addr_o;
  logic vec_ack_i, vec_req_o, cpu_en_o, bus_idle_o, ph1, ph3, irq_o;
  logic [31:0] vq[$], rq[$];
  logic [5:0] slots [10] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06,
    6'h09, 6'h0A, 6'h0B, 6'h0C};
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 mclk_i = ~mclk_i;
  irq_vector_and_power_modes irq_vector_and_power_modes_inst (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_irq_i(src[3:0]),
    .serial_tx_irq_i(src[4]), .serial_rx_irq_i(src[5]),
    .timer_zero_irq_i(src[6]), .timer_one_irq_i(src[7]),
    .dma_zero_irq_i(src[8]), .dma_one_irq_i(src[9]),
    .vec_ack_i(vec_ack_i), .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o),
    .cpu_en_o(cpu_en_o), .bus_idle_o(bus_idle_o),
    .out_clock_phase_one_o(ph1), .out_clock_phase_three_o(ph3),
    .irq_o(irq_o));
  core_ack_model core_ack_model_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .vec_req_i(vec_req_o), .delay_i(delay), .vec_ack_o(vec_ack_i));
  // ==========================
  // helpers: random, compare, bus cycles
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [31:0] va(input logic [5:0] s);
    return {8'h00, ptr, 2'b00, s};
  endfunction : va
  task automatic cmp(input string what, input logic [31:0] e,
      input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rq.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask : rd
  // one pulse on a source, new random accept delay
  task automatic pulse(input int i);
    r = xs();
    delay <= r[3:0];
    src <= 10'h001 << i;
    @(posedge mclk_i);
    src <= 10'h000;
  endtask : pulse
  // bounded wait until every noted vector was taken
  task automatic drain();
    repeat (300) if (vq.size() != 0) @(posedge mclk_i);
    cmp("vector queue", 32'h0, vq.size());
  endtask : drain
  task automatic finish_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  // ==========================
  // watcher: an unexpected vector meets an unknown note and fails
  always @(posedge mclk_i) begin
    if (rd_d) cmp("rdata", rq.pop_front(), rdata_o);
    if (vec_req_o && vec_ack_i) cmp("vector",
      vq.size() != 0 ? vq.pop_front() : 32'hX, {8'h00, vec_addr_o});
    rd_d = rd_i;
    if (++cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================
  // main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    cmp("reset vector", 32'h0, {8'h00, vec_addr_o});
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    rd(OFS_TABLE, 32'h0);
    rd(OFS_TRIG, 32'h0);
    rd(4'hF, 32'h0);
    r = xs();
    ptr = r[15:0];
    wr(OFS_TABLE, {16'h0, ptr});
    wr(OFS_MASK, 32'h3FF);
    for (int i = 0; i < 10; i++) begin
      vq.push_back(va(slots[i]));
      pulse(i);
      drain();
    end
    for (int t = 0; t < 32; t++) begin
      vq.push_back(va(6'h20 + t[5:0]));
      wr(OFS_TRAP, t);
      drain();
    end
    rd(OFS_VECTOR, va(6'h3F));
    // edge mode: a held pin gives one vector, then nothing
    wr(OFS_TRIG, 32'hF);
    vq.push_back(va(6'h02));
    src <= 10'h002;
    drain();
    repeat (30) @(posedge mclk_i);
    wr(OFS_MASK, 32'h0);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_TRIG, 32'h0);
    rd(OFS_STATUS, 32'h2);
    src <= 10'h000;
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h0);
    // masked event stays pending, unmasking raises irq and vector
    pulse(4);
    rd(OFS_STATUS, 32'h10);
    cmp("irq masked", 32'h0, irq_o);
    delay <= 4'hF;
    vq.push_back(va(6'h05));
    wr(OFS_MASK, 32'h3FF);
    cmp("irq raised", 32'h1, irq_o);
    drain();
    repeat (3) @(posedge mclk_i);
    cmp("irq cleared", 32'h0, irq_o);
    // deep idle: halted until an external pin wakes it
    wr(OFS_POWER, 32'h1);
    repeat (20) @(posedge mclk_i);
    cmp("deep idle", 32'hA, {bus_idle_o, cpu_en_o, ph1, ph3});
    rd(OFS_POWER, 32'h1);
    @(posedge mclk_i);
    vq.push_back(va(6'h04));
    pulse(3);
    drain();
    cmp("awake", 32'h0, bus_idle_o);
    // slow clock: one enable in every 16 cycles
    wr(OFS_POWER, 32'h2);
    rd(OFS_POWER, 32'h2);
    repeat (16) @(posedge mclk_i);
    n = 32'h0;
    repeat (160) begin
      @(posedge mclk_i);
      n = n + cpu_en_o;
    end
    cmp("slow enables", 32'd10, n);
    wr(OFS_POWER, 32'h0);
    repeat (4) @(posedge mclk_i);
    cmp("full rate", 32'h1, cpu_en_o);
    finish_test();
  end
endmodule : irq_vector_and_power_modes_bench
